// ===== msal_consts.vh
// Purpose: constants for the memory space address logic
// Assumes: included by the design files only
// Notes: definitions only
`ifndef MSAL_CONSTS_VH
`define MSAL_CONSTS_VH
`define MSAL_RESET_PC 23'h000000
`define MSAL_RESET_WORD2 24'h000002
`define MSAL_USER_TOP 24'h7FFFFF
`define MSAL_VEC_END 24'h000200
`define MSAL_IVT_START 24'h000004
`define MSAL_AIVT_START 24'h000100
`define MSAL_PC_STEP 23'h000002
`define MSAL_TBLPG_CFG_BIT 7
`define MSAL_EA_PSV_BIT 15
`define MSAL_RAM_BYTES 17'h04000
`define MSAL_RAM_WORDS 8192
`define MSAL_RAM_AW 13
`define MSAL_STEP_BYTE 16'h0001
`define MSAL_STEP_WORD 16'h0002
`endif

// ===== msal_core_model.sv
// Purpose: core-side program data returned for the view window
// Assumes: combinational return of the addressed word
// Notes: outside the view a shifting pattern is returned
`timescale 1ns/1ps
`default_nettype none
module msal_core_model (
    input wire logic [1:0] prog_src,
    input wire logic [23:0] prog_addr,
    output logic [23:0] prog_rdata
);
    // ********************
    // Read return
    // ********************
    // Inverted address so a wrong page or offset shows up
    assign prog_rdata = (prog_src == 2'h2) ? ~prog_addr :
        {prog_addr[11:0], 12'hA5C};
endmodule // msal_core_model
`default_nettype wire

// ===== msal_monitor.sv
// Purpose: port-level checks for msal_top
// Assumes: rst is synchronous, active high, on ref_clk
// Notes: bound below to every msal_top
`timescale 1ns/1ps
`default_nettype none
module msal_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic pc_inc,
    input wire logic pc_load,
    input wire logic [22:0] pc_value,
    input wire logic [1:0] prog_src,
    input wire logic [23:0] prog_addr,
    input wire logic prog_in_ivt,
    input wire logic rd_en,
    input wire logic rd_byte,
    input wire logic rd_postmod,
    input wire logic [15:0] rd_ea,
    input wire logic [15:0] rd_base_next,
    input wire logic [15:0] rd_data,
    input wire logic wr_en,
    input wire logic wr_byte,
    input wire logic [15:0] wr_ea,
    input wire logic addr_err_trap,
    input wire logic addr_err_flag
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ********************
    // Properties
    // ********************
    // First cycle after release still holds address zero
    property p_pc_rst;
        $fell(rst) |-> pc_value == 23'h000000 ##1 pc_value == 23'h000000;
    endproperty
    property p_pc_step;
        !$past(rst) && pc_inc && !pc_load |=>
            pc_value == $past(pc_value) + 23'h000002;
    endproperty
    property p_pc_addr; prog_src == 2'h0 |-> prog_addr == {1'h0, pc_value};
    endproperty
    property p_ivt;
        prog_in_ivt == (prog_addr >= 24'h000004 && prog_addr <= 24'h0000FF);
    endproperty
    property p_step;
        rd_postmod |-> rd_base_next == rd_ea + (rd_byte ? 16'h0001 : 16'h0002);
    endproperty
    property p_trap;
        addr_err_trap == (rd_en && !rd_byte && rd_ea[0] ||
            wr_en && !wr_byte && wr_ea[0]);
    endproperty
    property p_flag; addr_err_trap |=> addr_err_flag; endproperty
    property p_zero; rd_en && rd_ea[15:14] == 2'h1 |-> rd_data == 16'h0000;
    endproperty
    a_pc_rst: assert property (p_pc_rst) else $error("pc not zero");
    a_pc_step: assert property (p_pc_step) else $error("pc step");
    a_pc_addr: assert property (p_pc_addr) else $error("pc addr");
    a_ivt: assert property (p_ivt) else $error("ivt flag");
    a_step: assert property (p_step) else $error("post step");
    a_trap: assert property (p_trap) else $error("trap");
    a_flag: assert property (p_flag) else $error("flag");
    a_zero: assert property (p_zero) else $error("gap read");
    cover property (addr_err_trap);
    cover property (pc_inc ##1 pc_inc);
    cover property (rd_en && rd_ea[15]);
endmodule // msal_monitor
bind msal_top msal_monitor i_msal_monitor (.*);
`default_nettype wire

// ===== msal_ram.v
// Purpose: byte-laned data word storage for implemented data memory
// Assumes: one combinational read port and one write port on the core clock
// Notes: lanes share the word index, writes are per lane
`timescale 1ns/1ps
`default_nettype none
`include "msal_consts.vh"
module msal_ram (
    input wire ref_clk,
    input wire [`MSAL_RAM_AW-1:0] rd_idx,
    output wire [15:0] rd_word,
    input wire [`MSAL_RAM_AW-1:0] wr_idx,
    input wire [1:0] wr_lane,
    input wire [15:0] wr_word
);
    reg [7:0] lo_mem_r [0:`MSAL_RAM_WORDS-1];
    reg [7:0] hi_mem_r [0:`MSAL_RAM_WORDS-1];

    always @(posedge ref_clk) begin
        if (wr_lane[0]) begin
            lo_mem_r[wr_idx] <= wr_word[7:0];
        end
        if (wr_lane[1]) begin
            hi_mem_r[wr_idx] <= wr_word[15:8];
        end
    end

    assign rd_word = {hi_mem_r[rd_idx], lo_mem_r[rd_idx]};
endmodule // msal_ram
`default_nettype wire

// ===== msal_top.v
// Purpose: program and data space address logic of the signal controller
// Assumes: core execution unit drives requests on ref_clk
// Notes: data reads are combinational; writes land at the clock edge
`timescale 1ns/1ps
`default_nettype none
`include "msal_consts.vh"
module msal_top (
    input wire ref_clk,
    input wire rst,
    // Program side
    input wire pc_inc,
    input wire pc_dec,
    input wire pc_load,
    input wire [22:0] pc_load_val,
    input wire [1:0] prog_src,
    input wire [7:0] table_page_pointer,
    input wire [15:0] table_offset,
    input wire table_read_op,
    input wire table_write_op,
    input wire [7:0] psv_page,
    input wire byte_upper_sel,
    output reg [23:0] prog_addr,
    output reg prog_addr_ok,
    output reg prog_upper_word,
    output reg prog_in_vectors,
    output reg prog_in_ivt,
    output reg prog_in_aivt,
    output wire [22:0] pc_value,
    // Program-space view read data
    input wire [23:0] prog_rdata,
    // Data read side
    input wire rd_en,
    input wire rd_byte,
    input wire [15:0] rd_base,
    input wire rd_postmod,
    output wire [15:0] rd_ea,
    output wire [15:0] rd_base_next,
    output reg [15:0] rd_data,
    output reg rd_in_psv,
    // Data write side
    input wire wr_en,
    input wire wr_byte,
    input wire [15:0] wr_base,
    input wire wr_postmod,
    input wire [15:0] wr_data,
    output wire [15:0] wr_ea,
    output wire [15:0] wr_base_next,
    // Working register lane merge
    input wire [15:0] source_working_register,
    input wire [1:0] ext_op,
    output reg [15:0] wreg_result,
    // Exception interface
    output wire addr_err_trap,
    output wire addr_err_flag,
    input wire addr_err_clr
);
    // ************************************************************
    // Operation codes for the working register merge and program address sources
    // ************************************************************
    localparam [1:0] EXT_BYTE_LOAD = 2'h0;
    localparam [1:0] EXT_SIGN = 2'h1;
    localparam [1:0] EXT_ZERO = 2'h2;
    localparam [1:0] EXT_WORD = 2'h3;
    localparam [1:0] SRC_PC = 2'h0;
    localparam [1:0] SRC_TABLE = 2'h1;
    localparam [1:0] SRC_PSV = 2'h2;

    // Program counter sequencer states, one-hot
    localparam [1:0] ST_RESET = 2'h1;
    localparam [1:0] ST_RUN = 2'h2;

    reg [1:0] state_r;
    reg [22:0] pc_r;
    reg [22:0] pc_nxt;
    reg err_flag_r;

    // ************************************************************
    // Program counter
    // ************************************************************
    always @* begin
        pc_nxt = pc_r;
        case (state_r)
            ST_RESET: begin
                pc_nxt = `MSAL_RESET_PC;
            end
            ST_RUN: begin
                if (pc_load) begin
                    pc_nxt = {pc_load_val[22:1], 1'b0};
                end else if (pc_inc) begin
                    pc_nxt = pc_r + `MSAL_PC_STEP;
                end else if (pc_dec) begin
                    pc_nxt = pc_r - `MSAL_PC_STEP;
                end
            end
            default: begin
                pc_nxt = `MSAL_RESET_PC;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            state_r <= ST_RESET;
            pc_r <= 23'h000000;
        end else begin
            state_r <= ST_RUN;
            pc_r <= pc_nxt;
        end
    end

    assign pc_value = pc_r;

    // ************************************************************
    // Program address formation and checks
    // ************************************************************
    reg cfg_reach;
    always @* begin
        cfg_reach = 1'b0;
        case (prog_src)
            SRC_PC: begin
                prog_addr = {1'b0, pc_r};
            end
            SRC_TABLE: begin
                prog_addr = {table_page_pointer, table_offset};
                cfg_reach = table_read_op | table_write_op;
            end
            SRC_PSV: begin
                prog_addr = {1'b0, psv_page[6:0], rd_ea[14:0], byte_upper_sel};
            end
            default: begin
                prog_addr = {1'b0, pc_r};
            end
        endcase
        // upper half only by table ops
        prog_addr_ok = (prog_addr <= `MSAL_USER_TOP) ||
            (cfg_reach && table_page_pointer[`MSAL_TBLPG_CFG_BIT]);
        prog_upper_word = prog_addr[0];
        prog_in_vectors = prog_addr < `MSAL_VEC_END;
        prog_in_ivt = (prog_addr >= `MSAL_IVT_START) &&
            (prog_addr < `MSAL_AIVT_START);
        prog_in_aivt = (prog_addr >= `MSAL_AIVT_START) &&
            (prog_addr < `MSAL_VEC_END);
    end

    // ************************************************************
    // Data address generation
    // ************************************************************
    // 16-bit byte-granular EA
    assign rd_ea = rd_base;
    assign wr_ea = wr_base;
    assign rd_base_next = rd_postmod ?
        rd_base + (rd_byte ? `MSAL_STEP_BYTE : `MSAL_STEP_WORD) : rd_base;
    assign wr_base_next = wr_postmod ?
        wr_base + (wr_byte ? `MSAL_STEP_BYTE : `MSAL_STEP_WORD) : wr_base;

    // ************************************************************
    // Misalignment detection
    // ************************************************************
    wire rd_misalign;
    wire wr_misalign;
    assign rd_misalign = rd_en & ~rd_byte & rd_ea[0];
    assign wr_misalign = wr_en & ~wr_byte & wr_ea[0];
    assign addr_err_trap = rd_misalign | wr_misalign;

    // Set beats clear so no fault is lost
    always @(posedge ref_clk) begin
        if (rst) begin
            err_flag_r <= 1'b0;
        end else if (addr_err_trap) begin
            err_flag_r <= 1'b1;
        end else if (addr_err_clr) begin
            err_flag_r <= 1'b0;
        end
    end
    assign addr_err_flag = err_flag_r;

    // ************************************************************
    // Data memory decode
    // ************************************************************
    wire rd_in_ram;
    wire wr_in_ram;
    wire [15:0] ram_word;
    reg [1:0] lane_we;

    always @* begin
        rd_in_psv = rd_ea[`MSAL_EA_PSV_BIT];
    end
    assign rd_in_ram = ~rd_ea[`MSAL_EA_PSV_BIT] &&
        ({1'b0, rd_ea} < `MSAL_RAM_BYTES);
    assign wr_in_ram = ~wr_ea[`MSAL_EA_PSV_BIT] &&
        ({1'b0, wr_ea} < `MSAL_RAM_BYTES);

    always @* begin
        lane_we = 2'h0;
        if (wr_en && wr_in_ram && !wr_misalign) begin
            if (wr_byte) begin
                lane_we = wr_ea[0] ? 2'h2 : 2'h1;
            end else begin
                lane_we = 2'h3;
            end
        end
    end

    msal_ram i_msal_ram (
        .ref_clk(ref_clk),
        .rd_idx(rd_ea[`MSAL_RAM_AW:1]),
        .rd_word(ram_word),
        .wr_idx(wr_ea[`MSAL_RAM_AW:1]),
        .wr_lane(lane_we),
        .wr_word(wr_byte ? {wr_data[7:0], wr_data[7:0]} : wr_data)
    );

    // ************************************************************
    // Read data path
    // ************************************************************
    reg [15:0] word_sel;
    always @* begin
        if (rd_in_psv) begin
            // Lower 16 bits of the instruction word
            word_sel = prog_rdata[15:0];
        end else if (rd_in_ram) begin
            word_sel = ram_word;
        end else begin
            word_sel = 16'h0000;
        end
        if (rd_byte) begin
            rd_data = {8'h00, rd_ea[0] ? word_sel[15:8] : word_sel[7:0]};
        end else begin
            rd_data = word_sel;
        end
    end

    // ************************************************************
    // Working register result merge
    // ************************************************************
    always @* begin
        case (ext_op)
            EXT_BYTE_LOAD: begin
                wreg_result = {source_working_register[15:8], rd_data[7:0]};
            end
            EXT_SIGN: begin
                wreg_result = {{8{source_working_register[7]}},
                    source_working_register[7:0]};
            end
            EXT_ZERO: begin
                wreg_result = {8'h00, source_working_register[7:0]};
            end
            default: begin
                wreg_result = rd_data;
            end
        endcase
    end
endmodule // msal_top
`default_nettype wire

// ===== tb_msal_top.sv
// Purpose: directed checks of msal_top
// Assumes: 200 MHz ref_clk, synchronous rst
// Notes: comb outputs are sampled 1 ns after a change
`timescale 1ns/1ps
`default_nettype none
module tb_msal_top;
    logic ref_clk, rst, pc_inc, pc_dec, pc_load, table_read_op;
    logic table_write_op, byte_upper_sel, prog_addr_ok, prog_upper_word;
    logic prog_in_vectors, prog_in_ivt, prog_in_aivt, rd_en, rd_byte;
    logic rd_postmod, rd_in_psv, wr_en, wr_byte, wr_postmod, addr_err_clr;
    logic addr_err_trap, addr_err_flag;
    logic [22:0] pc_load_val, pc_value;
    logic [1:0] prog_src, ext_op;
    logic [7:0] table_page_pointer, psv_page;
    logic [23:0] prog_addr, prog_rdata;
    logic [15:0] table_offset, rd_base, rd_ea, rd_base_next, rd_data;
    logic [15:0] wr_base, wr_data, wr_ea, wr_base_next, wreg_result;
    logic [15:0] source_working_register;
    int miscompares, total_checks;
    msal_top i_msal_top (.*);
    msal_core_model i_msal_core_model (.*);
    // ********************
    // Clock and checks
    // ********************
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input string nm, input logic [23:0] e, g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic results;
        if (miscompares == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ********************
    // Scenarios
    // ********************
    task automatic t_pc;
        #1 chk("pc", 24'h0, pc_value);
        pc_inc <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 chk("pc", 24'h4, pc_value);
        chk("ivt", 24'h1, prog_in_ivt);
        chk("vec", 24'h1, prog_in_vectors);
        pc_inc <= 1'b0;
        pc_dec <= 1'b1;
        @(posedge ref_clk);
        #1 chk("pc", 24'h2, pc_value);
        chk("upper", 24'h0, prog_upper_word);
        pc_dec <= 1'b0;
        pc_load <= 1'b1;
        pc_load_val <= 23'h000100;
        @(posedge ref_clk);
        pc_load <= 1'b0;
        #1 chk("aivt", 24'h1, prog_in_aivt);
        chk("addr", 24'h000100, prog_addr);
    endtask
    task automatic t_tbl;
        prog_src <= 2'h1;
        table_page_pointer <= 8'hFF;
        table_read_op <= 1'b1;
        #1 chk("ok", 24'h1, prog_addr_ok);
        table_read_op <= 1'b0;
        #1 chk("ok", 24'h0, prog_addr_ok);
        prog_src <= 2'h0;
    endtask
    task automatic t_ram;
        @(posedge ref_clk);
        wr_en <= 1'b1;
        wr_base <= 16'h0010;
        wr_data <= 16'hBEEF;
        @(posedge ref_clk);
        wr_byte <= 1'b1;
        wr_base <= 16'h0011;
        wr_data <= 16'h1212;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        rd_base <= 16'h0010;
        #1 chk("word", 24'h12EF, rd_data);
        rd_byte <= 1'b1;
        rd_base <= 16'h0011;
        #1 chk("hi", 24'h12, rd_data);
        rd_base <= 16'h0010;
        #1 chk("lo", 24'hEF, rd_data);
    endtask
    task automatic t_mis;
        @(posedge ref_clk);
        rd_byte <= 1'b0;
        rd_base <= 16'h0011;
        #1 chk("trap", 24'h1, addr_err_trap);
        chk("mis", 24'h12EF, rd_data);
        rd_en <= 1'b0;
        wr_en <= 1'b1;
        wr_byte <= 1'b0;
        wr_base <= 16'h0011;
        wr_data <= 16'h5555;
        #1 chk("trap", 24'h1, addr_err_trap);
        @(posedge ref_clk);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        rd_base <= 16'h0010;
        #1 chk("kept", 24'h12EF, rd_data);
        chk("flag", 24'h1, addr_err_flag);
        addr_err_clr <= 1'b1;
        @(posedge ref_clk);
        addr_err_clr <= 1'b0;
        #1 chk("flag", 24'h0, addr_err_flag);
    endtask
    task automatic t_space;
        @(posedge ref_clk);
        rd_base <= 16'h4000;
        #1 chk("gap", 24'h0, rd_data);
        prog_src <= 2'h2;
        psv_page <= 8'h03;
        rd_base <= 16'h8010;
        rd_postmod <= 1'b1;
        #1 chk("view", 24'hFFDF, rd_data);
        chk("psv", 24'h1, rd_in_psv);
        chk("vaddr", 24'h030020, prog_addr);
        chk("next", 24'h8012, rd_base_next);
        rd_byte <= 1'b1;
        byte_upper_sel <= 1'b1;
        wr_byte <= 1'b1;
        wr_postmod <= 1'b1;
        wr_base <= 16'h0021;
        #1 chk("next", 24'h8011, rd_base_next);
        chk("wea", 24'h0021, wr_ea);
        chk("wnext", 24'h0022, wr_base_next);
        chk("upper", 24'h1, prog_upper_word);
        chk("vaddr", 24'h030021, prog_addr);
    endtask
    task automatic t_ext;
        @(posedge ref_clk);
        source_working_register <= 16'hAB80;
        ext_op <= 2'h1;
        #1 chk("sext", 24'hFF80, wreg_result);
        ext_op <= 2'h2;
        #1 chk("zext", 24'h0080, wreg_result);
        ext_op <= 2'h0;
        #1 chk("bload", 24'hABDE, wreg_result);
        ext_op <= 2'h3;
        #1 chk("wload", 24'h00DE, wreg_result);
    endtask
    initial begin
        {pc_inc, pc_dec, pc_load, table_read_op, table_write_op} = '0;
        {byte_upper_sel, rd_en, rd_byte, rd_postmod, wr_en, wr_byte} = '0;
        {wr_postmod, addr_err_clr, pc_load_val, prog_src, ext_op} = '0;
        {table_page_pointer, psv_page, table_offset, rd_base} = '0;
        {wr_base, wr_data, source_working_register} = '0;
        rst = 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        t_pc;
        t_tbl;
        t_ram;
        t_mis;
        t_space;
        t_ext;
        results;
    end
endmodule // tb_msal_top
`default_nettype wire
